/* File: exec_params.svh */
// Purpose: constants for the data-move execution block
// Assumes: 8-bit bus address, byte offsets on 16-bit data
// Notes: definitions only
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

`define RAM_AW_DEFAULT 12
`define PTR_W 16
`define PTR_ONE 16'h0001
`define REG_WORK 8'h00
`define REG_BANK 8'h04
`define REG_PAGE 8'h08
`define REG_STATUS 8'h0C
`define REG_PTR0 8'h10
`define REG_PTR1 8'h14
`define REG_MEM_ADDR 8'h18
`define REG_MEM_DATA 8'h1C
`define REG_STATE 8'h20
`define ZERO_BIT 2
`define WIN0_ADDR 7'h00
`define WIN1_ADDR 7'h01
`define WORK_RST 8'h00
`define BANK_RST 5'h00
`define PAGE_RST 7'h00
`define STATUS_RST 8'h18
`define PTR_RST 16'h0000

`endif

/* File: exec_pkg.sv */
// Purpose: types shared by the data-move execution block
// Assumes: nothing
// Notes: encodings of update mode follow the instruction field
package exec_pkg;
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_LOAD_IND = 3'h1,
        OP_LOAD_BANK = 3'h2,
        OP_LOAD_PAGE = 3'h3,
        OP_LOAD_WORK = 3'h4,
        OP_STORE_FILE = 3'h5
    } op_type;
    typedef enum logic [1:0] {
        PRE_INC = 2'h0,
        PRE_DEC = 2'h1,
        POST_INC = 2'h2,
        POST_DEC = 2'h3
    } mode_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_LOAD = 3'h2,
        ST_STORE = 3'h4
    } state_type;
endpackage

/* File: data_ram.sv */
// Purpose: byte-wide data memory, one write and one read port
// Assumes: read data registered, one cycle after the read enable
// Notes: no reset on the array; contents undefined until written
`timescale 1ns/10ps
`default_nettype none
module data_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    initial begin
        if (AW < 7 || AW > 16) begin
            $error("data_ram: AW out of range");
        end
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

/* File: data_move_exec.sv */
// Purpose: execution of the data-move instruction group
// Assumes: one command at a time, taken while cmd_ready is high
// Notes: register port has read data one cycle after bus_rd
//
// Contract
// - indirect load puts addressed byte into work
// - window access redirects to pointer address
// - mode field picks pre/post increment/decrement
// - two pointers; relative offset leaves pointer alone
// - pointer is 16 bits and wraps
// - indirect load sets zero flag only
// - bank literal loads bank select, no flags
// - page literal loads high latch, no flags
// - work literal loads work, one cycle
// - store copies work to file register
`timescale 1ns/10ps
`default_nettype none
`include "exec_params.svh"
module data_move_exec
    import exec_pkg::*;
#(
    parameter int RAM_AW = `RAM_AW_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire op_type cmd_op,
    input wire logic cmd_sel,
    input wire mode_type cmd_mode,
    input wire logic cmd_rel,
    input wire logic [7:0] cmd_lit,
    output logic cmd_ready,
    output logic cmd_done,
    input wire logic [7:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    output logic [7:0] work,
    output logic [4:0] bank_select_reg,
    output logic [6:0] program_counter_high_latch,
    output logic [7:0] status
);
    initial begin
        if (RAM_AW < 7 || RAM_AW > `PTR_W) begin
            $error("data_move_exec: RAM_AW out of range");
        end
    end

    function automatic logic is_window(input logic [6:0] f);
        is_window = (f == `WIN0_ADDR) || (f == `WIN1_ADDR);
    endfunction

    // returns {effective address, updated pointer}
    function automatic logic [31:0] ind_calc(input logic [15:0] p, input mode_type m,
                                             input logic rel, input logic [5:0] k);
        logic [15:0] ea;
        logic [15:0] np;
        ea = p;
        np = p;
        if (rel) begin
            ea = p + {{10{k[5]}}, k};
        end else begin
            case (m)
                PRE_INC: begin
                    ea = p + `PTR_ONE;
                    np = p + `PTR_ONE;
                end
                PRE_DEC: begin
                    ea = p - `PTR_ONE;
                    np = p - `PTR_ONE;
                end
                POST_INC: np = p + `PTR_ONE;
                POST_DEC: np = p - `PTR_ONE;
                default: np = p;
            endcase
        end
        ind_calc = {ea, np};
    endfunction

    state_type state, next_state;
    logic [15:0] ptr [2];
    logic [15:0] next_ptr [2];
    logic [7:0] next_work;
    logic [4:0] next_bank;
    logic [6:0] next_page;
    logic [7:0] next_status;
    logic [RAM_AW-1:0] mem_addr, next_mem_addr;
    logic [RAM_AW-1:0] store_addr, next_store_addr;
    logic next_ready, next_done;
    logic [15:0] next_rdata;
    logic ram_we, ram_re;
    logic [RAM_AW-1:0] ram_waddr, ram_raddr;
    logic [7:0] ram_wdata, ram_q;
    logic accept, bus_mem_wr;
    logic [15:0] cur_ptr;
    logic [31:0] calc;
    logic [15:0] file_addr;

    assign accept = cmd_valid && cmd_ready;
    assign bus_mem_wr = bus_wr && (bus_addr == `REG_MEM_DATA);
    assign cur_ptr = ptr[cmd_sel];
    assign calc = ind_calc(cur_ptr, cmd_mode, cmd_rel, cmd_lit[5:0]);
    assign file_addr = {4'h0, bank_select_reg, cmd_lit[6:0]};

    data_ram #(.AW(RAM_AW), .DW(8)) ram (
        .clk(clk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .re(ram_re),
        .raddr(ram_raddr),
        .rdata(ram_q)
    );

    always_comb begin
        next_state = state;
        for (int i = 0; i < 2; i++) begin
            next_ptr[i] = ptr[i];
        end
        next_work = work;
        next_bank = bank_select_reg;
        next_page = program_counter_high_latch;
        next_status = status;
        next_mem_addr = mem_addr;
        next_store_addr = store_addr;
        next_done = 1'b0;
        ram_we = 1'b0;
        ram_waddr = mem_addr;
        ram_wdata = bus_wdata[7:0];
        ram_re = 1'b0;
        ram_raddr = calc[16 +: RAM_AW];
        // bus writes first; a same-cycle instruction result overrides them, except a store, which yields to a bus memory write
        if (bus_wr) begin
            case (bus_addr)
                `REG_WORK: next_work = bus_wdata[7:0];
                `REG_BANK: next_bank = bus_wdata[4:0];
                `REG_PAGE: next_page = bus_wdata[6:0];
                `REG_STATUS: next_status = bus_wdata[7:0];
                `REG_PTR0: next_ptr[0] = bus_wdata;
                `REG_PTR1: next_ptr[1] = bus_wdata;
                `REG_MEM_ADDR: next_mem_addr = bus_wdata[RAM_AW-1:0];
                `REG_MEM_DATA: ram_we = 1'b1;
                default: ;
            endcase
        end
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    case (cmd_op)
                        OP_LOAD_IND: begin
                            ram_re = 1'b1;
                            next_ptr[cmd_sel] = calc[15:0];
                            next_state = ST_LOAD;
                        end
                        OP_LOAD_BANK: begin
                            next_bank = cmd_lit[4:0];
                            next_done = 1'b1;
                        end
                        OP_LOAD_PAGE: begin
                            next_page = cmd_lit[6:0];
                            next_done = 1'b1;
                        end
                        OP_LOAD_WORK: begin
                            next_work = cmd_lit;
                            next_done = 1'b1;
                        end
                        OP_STORE_FILE: begin
                            // the window has no storage; go through the pointer
                            if (is_window(cmd_lit[6:0])) begin
                                next_store_addr = ptr[cmd_lit[0]][RAM_AW-1:0];
                            end else begin
                                next_store_addr = file_addr[RAM_AW-1:0];
                            end
                            next_state = ST_STORE;
                        end
                        default: next_done = 1'b1;
                    endcase
                end
            end
            ST_LOAD: begin
                next_work = ram_q;
                next_status[`ZERO_BIT] = (ram_q == `WORK_RST);
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            ST_STORE: begin
                // bus preload owns the write port; the store waits a cycle
                if (!bus_mem_wr) begin
                    ram_we = 1'b1;
                    ram_waddr = store_addr;
                    ram_wdata = work;
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_ready = (next_state == ST_IDLE);
    end

    always_comb begin
        next_rdata = 16'h0000;
        if (bus_rd) begin
            case (bus_addr)
                `REG_WORK: next_rdata = {8'h00, work};
                `REG_BANK: next_rdata = {11'h000, bank_select_reg};
                `REG_PAGE: next_rdata = {9'h000, program_counter_high_latch};
                `REG_STATUS: next_rdata = {8'h00, status};
                `REG_PTR0: next_rdata = ptr[0];
                `REG_PTR1: next_rdata = ptr[1];
                `REG_MEM_ADDR: next_rdata = 16'(mem_addr);
                `REG_STATE: next_rdata = {13'h0000, state};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            for (int i = 0; i < 2; i++) begin
                ptr[i] <= `PTR_RST;
            end
            work <= `WORK_RST;
            bank_select_reg <= `BANK_RST;
            program_counter_high_latch <= `PAGE_RST;
            status <= `STATUS_RST;
            mem_addr <= '0;
            store_addr <= '0;
            cmd_ready <= 1'b1;
            cmd_done <= 1'b0;
            bus_rdata <= 16'h0000;
        end else begin
            state <= next_state;
            for (int i = 0; i < 2; i++) begin
                ptr[i] <= next_ptr[i];
            end
            work <= next_work;
            bank_select_reg <= next_bank;
            program_counter_high_latch <= next_page;
            status <= next_status;
            mem_addr <= next_mem_addr;
            store_addr <= next_store_addr;
            cmd_ready <= next_ready;
            cmd_done <= next_done;
            bus_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic acc_ind;
    assign acc_ind = accept && cmd_op == OP_LOAD_IND;

    AST_LOAD_DATA: assert property (
        state == ST_LOAD |=> work == $past(ram_q) && cmd_done && cmd_ready)
        else $error("load did not place memory byte in work");
    AST_LOAD_SEQ: assert property (
        acc_ind |-> ram_re ##1 (state == ST_LOAD && !cmd_ready) ##1 cmd_done)
        else $error("load sequence wrong");
    AST_WINDOW: assert property (
        accept && cmd_op == OP_STORE_FILE && cmd_lit[6:0] == `WIN1_ADDR
        |=> store_addr == $past(ptr[1][RAM_AW-1:0]))
        else $error("window store not redirected");
    AST_PREINC: assert property (
        acc_ind && !cmd_rel && cmd_mode == PRE_INC
        |-> ram_raddr == RAM_AW'(cur_ptr + `PTR_ONE)
        ##1 ptr[$past(cmd_sel)] == $past(cur_ptr) + `PTR_ONE)
        else $error("preincrement wrong");
    AST_POSTDEC: assert property (
        acc_ind && !cmd_rel && cmd_mode == POST_DEC
        |-> ram_raddr == cur_ptr[RAM_AW-1:0]
        ##1 ptr[$past(cmd_sel)] == $past(cur_ptr) - `PTR_ONE)
        else $error("postdecrement wrong");
    AST_REL: assert property (
        acc_ind && cmd_rel && !(bus_wr && bus_addr[7:3] == 5'h02)
        |=> ptr[$past(cmd_sel)] == $past(cur_ptr))
        else $error("relative form moved pointer");
    AST_WRAP: assert property (
        acc_ind && !cmd_rel && cmd_mode == POST_INC && cur_ptr == 16'hFFFF
        |=> ptr[$past(cmd_sel)] == 16'h0000)
        else $error("pointer did not wrap");
    AST_ZERO: assert property (
        state == ST_LOAD && !(bus_wr && bus_addr == `REG_STATUS)
        |=> status[`ZERO_BIT] == (work == `WORK_RST)
        && (status | 8'h04) == ($past(status) | 8'h04))
        else $error("zero flag wrong or other flags touched");
    AST_BANK: assert property (
        accept && cmd_op == OP_LOAD_BANK |=> bank_select_reg == $past(cmd_lit[4:0]) && cmd_done)
        else $error("bank literal not loaded");
    AST_PAGE: assert property (
        accept && cmd_op == OP_LOAD_PAGE
        |=> program_counter_high_latch == $past(cmd_lit[6:0]))
        else $error("page literal not loaded");
    AST_LIT: assert property (
        accept && cmd_op == OP_LOAD_WORK |=> work == $past(cmd_lit) && cmd_done && cmd_ready)
        else $error("work literal not loaded in one cycle");
    AST_STORE: assert property (
        state == ST_STORE && !bus_mem_wr |-> ram_we && ram_wdata == work
        && ram_waddr == store_addr)
        else $error("store did not write work");
    AST_PREDEC: assert property (
        acc_ind && !cmd_rel && cmd_mode == PRE_DEC
        |-> ram_raddr == RAM_AW'(cur_ptr - `PTR_ONE))
        else $error("predecrement address wrong");

    COV_LOAD: cover property (acc_ind ##2 cmd_done);
    COV_REL: cover property (acc_ind && cmd_rel && cmd_lit[5]);
    COV_WIN_STORE: cover property (accept && cmd_op == OP_STORE_FILE && is_window(cmd_lit[6:0]));
    COV_STALL: cover property (state == ST_STORE && bus_mem_wr);
endmodule
`default_nettype wire

/* File: mem_model.sv */
// Purpose: data memory mirror standing behind the execution block
// Assumes: memory indexed by the low AW address bits
// Notes: behavioural, filled and read by the bench
`timescale 1ns/10ps
`default_nettype none
module mem_model #(
    parameter int AW = 8
);
    logic [7:0] mem [0:(1<<AW)-1];
    function automatic logic [15:0] idx(input logic [15:0] a);
        return a & 16'((1 << AW) - 1);
    endfunction
    task automatic poke(input logic [15:0] a, input logic [7:0] d);
        mem[idx(a)] = d;
    endtask
    function automatic logic [7:0] peek(input logic [15:0] a);
        return mem[idx(a)];
    endfunction
    // window slots hold nothing, they stand for the pointer target
    function automatic logic [15:0] file_addr(input logic [4:0] b, input logic [6:0] f,
                                              input logic [15:0] p0, input logic [15:0] p1);
        if (f == 7'h00) return p0;
        if (f == 7'h01) return p1;
        return {4'h0, b, f};
    endfunction
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the data-move execution block
// Assumes: memory filled over the register port before indirect loads
// Notes: small memory so pointer wrap lands on known bytes
`timescale 1ns/10ps
`default_nettype none
`include "exec_params.svh"
module testbench
    import exec_pkg::*;
;
    localparam int AW = 8;
    logic clk, rst_n, cmd_valid, cmd_sel, cmd_rel, cmd_ready, cmd_done, bus_wr, bus_rd;
    op_type cmd_op;
    mode_type cmd_mode;
    logic [7:0] cmd_lit, bus_addr, work, status, m_work, m_status, d;
    logic [15:0] bus_wdata, bus_rdata, a, rd;
    logic [4:0] bank_select_reg, m_bank;
    logic [6:0] program_counter_high_latch, m_page;
    logic [15:0] m_ptr [2];
    logic [31:0] seed;
    int num_errors, checks, stall;

    data_move_exec #(.RAM_AW(AW)) u_data_move_exec (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_mode(cmd_mode),
        .cmd_rel(cmd_rel), .cmd_lit(cmd_lit), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .work(work), .bank_select_reg(bank_select_reg),
        .program_counter_high_latch(program_counter_high_latch), .status(status));
    mem_model #(.AW(AW)) u_mem_model ();

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string s);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic bw(input logic [7:0] ad, input logic [15:0] v);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= ad;
        bus_wdata <= v;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic br(input logic [7:0] ad, output logic [15:0] v);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= ad;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 v = bus_rdata;
    endtask
    task automatic cmd(input op_type op, input logic s, input mode_type md, input logic rl,
                       input logic [7:0] lit);
        int n;
        logic [15:0] p, ea;
        logic busy;
        n = 0;
        busy = (op == OP_LOAD_IND) || (op == OP_STORE_FILE);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_sel <= s;
        cmd_mode <= md;
        cmd_rel <= rl;
        cmd_lit <= lit;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        if (busy) chk(16'(cmd_ready), 16'h0000, "ready while busy");
        while (cmd_done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        case (op)
            OP_LOAD_BANK: m_bank = lit[4:0];
            OP_LOAD_PAGE: m_page = lit[6:0];
            OP_LOAD_WORK: m_work = lit;
            OP_STORE_FILE: u_mem_model.poke(u_mem_model.file_addr(m_bank, lit[6:0],
                m_ptr[0], m_ptr[1]), m_work);
            OP_LOAD_IND: begin
                p = m_ptr[s];
                ea = p + {{10{lit[5]}}, lit[5:0]};
                if (!rl) begin
                    // 16-bit arithmetic gives the wrap for free
                    if (md == PRE_INC || md == POST_INC) p = p + 16'h0001;
                    else p = p - 16'h0001;
                    ea = (md == PRE_INC || md == PRE_DEC) ? p : m_ptr[s];
                end
                m_ptr[s] = p;
                m_work = u_mem_model.peek(ea);
                m_status[`ZERO_BIT] = (m_work == 8'h00);
            end
            default: ;
        endcase
        chk(16'(n), busy ? 16'(1 + stall) : 16'h0000, "done latency");
        chk(16'(work), 16'(m_work), "work");
        chk(16'(bank_select_reg), 16'(m_bank), "bank");
        chk(16'(program_counter_high_latch), 16'(m_page), "page");
        chk(16'(status), 16'(m_status), "status");
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (8000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        {rst_n, cmd_valid, cmd_sel, cmd_rel, bus_wr, bus_rd} = '0;
        cmd_op = OP_NOP;
        cmd_mode = PRE_INC;
        {cmd_lit, bus_addr, bus_wdata} = '0;
        num_errors = 0;
        checks = 0;
        stall = 0;
        seed = 32'h2f33;
        m_work = `WORK_RST;
        m_status = `STATUS_RST;
        m_bank = `BANK_RST;
        m_page = `PAGE_RST;
        m_ptr[0] = `PTR_RST;
        m_ptr[1] = `PTR_RST;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        br(`REG_STATUS, rd);
        chk(rd, 16'(m_status), "status reset");
        br(`REG_STATE, rd);
        chk(rd, 16'(ST_IDLE), "state idle");
        br(8'h24, rd);
        chk(rd, 16'h0000, "unmapped read");
        bw(`REG_WORK, 16'h00A5);
        m_work = 8'hA5;
        br(`REG_WORK, rd);
        chk(rd, 16'(m_work), "work write");
        $display("reset test done");
        // literal codes, all-ones first so unused literal bits are exercised
        for (int i = 0; i < 13; i++) begin
            seed = lfsr(seed);
            cmd(op_type'(2 + i % 3), 1'b0, PRE_INC, 1'b0, (i < 3) ? 8'hFF : seed[7:0]);
        end
        cmd(OP_NOP, 1'b0, PRE_INC, 1'b0, 8'hFF);
        $display("literal test done");
        // zero bytes every 17 addresses to set and clear the zero flag
        for (int i = 0; i < (1 << AW); i++) begin
            seed = lfsr(seed);
            d = (i % 17 == 0) ? 8'h00 : seed[7:0];
            bw(`REG_MEM_ADDR, 16'(i));
            bw(`REG_MEM_DATA, {8'h00, d});
            u_mem_model.poke(16'(i), d);
        end
        br(`REG_MEM_ADDR, rd);
        chk(rd, 16'((1 << AW) - 1), "mem addr");
        m_ptr[0] = 16'hFFFF;
        m_ptr[1] = 16'h0000;
        bw(`REG_PTR0, m_ptr[0]);
        bw(`REG_PTR1, m_ptr[1]);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            d = (i % 3 == 0) ? 8'h20 : (i % 3 == 1) ? 8'h1F : seed[7:0];
            cmd(OP_LOAD_IND, i[2], mode_type'(i % 4), i >= 8, d);
            br(i[2] ? `REG_PTR1 : `REG_PTR0, rd);
            chk(rd, m_ptr[i[2]], "pointer");
        end
        $display("indirect load test done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            cmd(OP_LOAD_WORK, 1'b0, PRE_INC, 1'b0, seed[7:0]);
            cmd(OP_LOAD_BANK, 1'b0, PRE_INC, 1'b0, {3'h0, seed[12:8]});
            d = (i < 2) ? 8'(i) : {1'b0, seed[22:16]};
            a = u_mem_model.file_addr(m_bank, d[6:0], m_ptr[0], m_ptr[1]);
            cmd(OP_STORE_FILE, 1'b0, PRE_INC, 1'b0, d);
            bw(`REG_PTR0, a);
            m_ptr[0] = a;
            cmd(OP_LOAD_IND, 1'b0, PRE_INC, 1'b1, 8'h00); // read back
        end
        $display("store test done");
        // bus preload lands in the store cycle, so the store must wait one cycle
        bw(`REG_MEM_ADDR, 16'h0033);
        u_mem_model.poke(16'h0033, 8'h5A);
        stall = 1;
        fork
            cmd(OP_STORE_FILE, 1'b0, PRE_INC, 1'b0, 8'h00);
            begin
                @(posedge clk);
                bw(`REG_MEM_DATA, 16'h005A);
            end
        join
        stall = 0;
        cmd(OP_LOAD_IND, 1'b0, PRE_INC, 1'b1, 8'h00);
        bw(`REG_PTR0, 16'h0033);
        m_ptr[0] = 16'h0033;
        cmd(OP_LOAD_IND, 1'b0, PRE_INC, 1'b1, 8'h00);
        $display("stall test done");
        wrap_up();
    end
endmodule
`default_nettype wire
